// ### rtl/tca_pkg.sv
// Shared constants, types and register layout of the temperature alarm controller
package tca_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_DIV = 1000;
    localparam int CONV_TIME_MS = 60;
    localparam int RATE0_MS = 4000;
    localparam int RATE1_MS = 1000;
    localparam int RATE2_MS = 250;
    localparam int RATE3_MS = 125;
    localparam int CONV_CYC = CONV_TIME_MS * (CLK_HZ / MS_DIV);
    localparam int RATE0_CYC = RATE0_MS * (CLK_HZ / MS_DIV);
    localparam int RATE1_CYC = RATE1_MS * (CLK_HZ / MS_DIV);
    localparam int RATE2_CYC = RATE2_MS * (CLK_HZ / MS_DIV);
    localparam int RATE3_CYC = RATE3_MS * (CLK_HZ / MS_DIV);
    localparam int TMR_W = 26;

    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_CFG = 2'h1;
    localparam logic [1:0] PTR_LOW = 2'h2;
    localparam logic [1:0] PTR_HIGH = 2'h3;

    localparam int CFG_ALT_BIT = 15;
    localparam int CFG_FQ_LO = 11;
    localparam int CFG_TM_BIT = 9;
    localparam int CFG_SD_BIT = 8;
    localparam int CFG_EM_BIT = 7;
    localparam int CFG_TO_BIT = 4;
    localparam int CFG_EC_BIT = 3;
    localparam int CFG_CR_LO = 1;
    localparam int CFG_OS_BIT = 0;

    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h00c0;
    localparam logic [15:0] LOW_RST = 16'h4b00;
    localparam logic [15:0] HIGH_RST = 16'h5000;

    localparam logic [6:0] ADDR_BASE7 = 7'h48;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_MACK, I_NEXT} tca_i2c_e;
    typedef enum logic [1:0] {CV_CONV, CV_IDLE, CV_SHUT} tca_cv_e;
endpackage : tca_pkg

// ### rtl/tca_temp_alarm_ctrl.sv
// Conversion scheduler, limit alarm and two-wire slave register port
`timescale 1ns/10ps
module tca_temp_alarm_ctrl #(
    parameter int CONV_CYC = tca_pkg::CONV_CYC,
    parameter int RATE0_CYC = tca_pkg::RATE0_CYC,
    parameter int RATE1_CYC = tca_pkg::RATE1_CYC,
    parameter int RATE2_CYC = tca_pkg::RATE2_CYC,
    parameter int RATE3_CYC = tca_pkg::RATE3_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic [2:0] addrSel,
    input wire logic [15:0] tempSample,
    output logic convActive,
    output logic overTempFlag
);
    localparam logic [tca_pkg::TMR_W-1:0] CONV_LAST = tca_pkg::TMR_W'(CONV_CYC - 1);

    typedef struct packed {
        logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3;
        logic [2:0] addrS1, addrS2;
        tca_pkg::tca_i2c_e i2c;
        logic [3:0] bitCnt;
        logic [2:0] byteIdx;
        logic [7:0] shift, wrMsb;
        logic rw, txLsb, sdaOeN, sdaOut;
        logic [1:0] ptr;
        tca_pkg::tca_cv_e cv;
        logic [tca_pkg::TMR_W-1:0] timer;
        logic oneShot, convBusy;
        logic [15:0] temp, low, high;
        logic [1:0] fq, cr;
        logic tm, sd, em, to, ec, flag, waitHigh;
        logic [2:0] hiCnt, loCnt;
    } tca_state_s;

    tca_state_s st, next_st;
    logic sclRise, sclFall, startEv, stopEv, readEv, wrEv;
    logic osReq, convDone, setEv;
    logic [15:0] wrData, rdWord, cfgWord, sampled;
    logic [7:0] nextByte;
    logic [2:0] depth;

    // Bit zero does not exist in 15-bit weighting
    function automatic logic [15:0] maskRes(input logic [15:0] v, input logic em);
        maskRes = em ? v : {v[15:1], 1'b0};
    endfunction : maskRes

    function automatic logic [2:0] satInc(input logic [2:0] c);
        satInc = (c == 3'h7) ? c : c + 3'h1;
    endfunction : satInc

    function automatic logic [2:0] depthOf(input logic [1:0] code);
        depthOf = (code == 2'h3) ? 3'h6 : (3'h1 << code);
    endfunction : depthOf

    function automatic logic [tca_pkg::TMR_W-1:0] periodLast(input logic [1:0] code);
        case (code)
            2'h0: periodLast = tca_pkg::TMR_W'(RATE0_CYC - 1);
            2'h1: periodLast = tca_pkg::TMR_W'(RATE1_CYC - 1);
            2'h2: periodLast = tca_pkg::TMR_W'(RATE2_CYC - 1);
            default: periodLast = tca_pkg::TMR_W'(RATE3_CYC - 1);
        endcase
    endfunction : periodLast

    always_comb begin
        next_st = st;
        next_st.sclS1 = sclIn;
        next_st.sclS2 = st.sclS1;
        next_st.sclS3 = st.sclS2;
        next_st.sdaS1 = sdaIn;
        next_st.sdaS2 = st.sdaS1;
        next_st.sdaS3 = st.sdaS2;
        next_st.addrS1 = addrSel;
        next_st.addrS2 = st.addrS1;
        sclRise = st.sclS2 & ~st.sclS3;
        sclFall = ~st.sclS2 & st.sclS3;
        // Data edge with clock high on both samples marks start or stop
        startEv = st.sclS2 & st.sclS3 & ~st.sdaS2 & st.sdaS3;
        stopEv = st.sclS2 & st.sclS3 & st.sdaS2 & ~st.sdaS3;
        readEv = 1'b0;
        wrEv = 1'b0;
        osReq = 1'b0;
        convDone = 1'b0;
        setEv = 1'b0;
        wrData = {st.wrMsb, st.shift};
        cfgWord = {st.flag, 2'h0, st.fq, 1'b0, st.tm, st.sd, st.em, 1'b1, 1'b0,
                   st.to, st.ec, st.cr, st.oneShot};
        case (st.ptr)
            tca_pkg::PTR_TEMP: rdWord = st.temp;
            tca_pkg::PTR_CFG: rdWord = cfgWord;
            tca_pkg::PTR_LOW: rdWord = maskRes(st.low, st.em);
            default: rdWord = maskRes(st.high, st.em);
        endcase
        nextByte = st.txLsb ? rdWord[15:8] : rdWord[7:0];
        sampled = maskRes(tempSample, st.em);
        depth = depthOf(st.fq);

        // Serial slave; it never drives the clock and only answers
        if (startEv) begin
            next_st.i2c = tca_pkg::I_RX;
            next_st.bitCnt = 4'h0;
            next_st.byteIdx = 3'h0;
            next_st.sdaOeN = 1'b1;
        end else if (stopEv) begin
            next_st.i2c = tca_pkg::I_IDLE;
            next_st.sdaOeN = 1'b1;
        end else begin
            case (st.i2c)
                tca_pkg::I_RX: begin
                    if (sclRise && st.bitCnt < tca_pkg::BYTE_BITS) begin
                        next_st.shift = {st.shift[6:0], st.sdaS2};
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end
                    // Ninth clock carries the acknowledge
                    if (sclFall && st.bitCnt == tca_pkg::BYTE_BITS) begin
                        next_st.i2c = tca_pkg::I_ACK;
                        next_st.sdaOeN = 1'b0;
                        case (st.byteIdx)
                            3'h0: begin
                                if (st.shift[7:1] == {tca_pkg::ADDR_BASE7[6:3], st.addrS2}) begin
                                    next_st.rw = st.shift[0];
                                    readEv = st.shift[0];
                                end else begin
                                    next_st.i2c = tca_pkg::I_IDLE;
                                    next_st.sdaOeN = 1'b1;
                                end
                            end
                            3'h1: next_st.ptr = st.shift[1:0];
                            3'h2: next_st.wrMsb = st.shift;
                            3'h3: wrEv = 1'b1;
                            default: begin
                                next_st.i2c = tca_pkg::I_IDLE;
                                next_st.sdaOeN = 1'b1;
                            end
                        endcase
                    end
                end
                tca_pkg::I_ACK: begin
                    if (sclFall) begin
                        next_st.byteIdx = st.byteIdx + 3'h1;
                        if (st.rw) begin
                            next_st.i2c = tca_pkg::I_TX;
                            next_st.txLsb = 1'b0;
                            next_st.shift = rdWord[15:8];
                            next_st.sdaOeN = rdWord[15];
                            next_st.bitCnt = 4'h1;
                        end else begin
                            next_st.i2c = tca_pkg::I_RX;
                            next_st.bitCnt = 4'h0;
                            next_st.sdaOeN = 1'b1;
                        end
                    end
                end
                tca_pkg::I_TX: begin
                    // Data changes only after the clock falls
                    if (sclFall) begin
                        if (st.bitCnt == tca_pkg::BYTE_BITS) begin
                            next_st.i2c = tca_pkg::I_MACK;
                            next_st.sdaOeN = 1'b1;
                        end else begin
                            next_st.sdaOeN = st.shift[6];
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.bitCnt = st.bitCnt + 4'h1;
                        end
                    end
                end
                tca_pkg::I_MACK: begin
                    if (sclRise) begin
                        next_st.i2c = st.sdaS2 ? tca_pkg::I_IDLE : tca_pkg::I_NEXT;
                    end
                end
                tca_pkg::I_NEXT: begin
                    if (sclFall) begin
                        next_st.i2c = tca_pkg::I_TX;
                        next_st.txLsb = ~st.txLsb;
                        next_st.shift = nextByte;
                        next_st.sdaOeN = nextByte[7];
                        next_st.bitCnt = 4'h1;
                    end
                end
                default: next_st.sdaOeN = 1'b1;
            endcase
        end

        // Register writes land whatever the conversion state
        if (wrEv) begin
            case (st.ptr)
                tca_pkg::PTR_CFG: begin
                    next_st.fq = wrData[tca_pkg::CFG_FQ_LO +: 2];
                    next_st.tm = wrData[tca_pkg::CFG_TM_BIT];
                    next_st.sd = wrData[tca_pkg::CFG_SD_BIT];
                    next_st.em = wrData[tca_pkg::CFG_EM_BIT];
                    next_st.to = wrData[tca_pkg::CFG_TO_BIT];
                    next_st.ec = wrData[tca_pkg::CFG_EC_BIT];
                    next_st.cr = wrData[tca_pkg::CFG_CR_LO +: 2];
                    osReq = wrData[tca_pkg::CFG_OS_BIT] & wrData[tca_pkg::CFG_SD_BIT];
                end
                // Stored with bit zero masked at the current resolution; a later resolution change leaves them alone
                tca_pkg::PTR_LOW: next_st.low = maskRes(wrData, st.em);
                tca_pkg::PTR_HIGH: next_st.high = maskRes(wrData, st.em);
                default: next_st.temp = st.temp;
            endcase
        end

        // Timer counts from the start of each conversion period
        case (st.cv)
            tca_pkg::CV_CONV: begin
                next_st.timer = st.timer + tca_pkg::TMR_W'(1'b1);
                if (st.timer == CONV_LAST) begin
                    convDone = 1'b1;
                    if (st.oneShot || st.sd) begin
                        next_st.cv = tca_pkg::CV_SHUT;
                        next_st.oneShot = 1'b0;
                    end else begin
                        next_st.cv = tca_pkg::CV_IDLE;
                    end
                end
            end
            tca_pkg::CV_IDLE: begin
                next_st.timer = st.timer + tca_pkg::TMR_W'(1'b1);
                if (st.sd) begin
                    next_st.cv = tca_pkg::CV_SHUT;
                end else if (st.timer >= periodLast(st.cr)) begin
                    next_st.timer = '0;
                    next_st.cv = tca_pkg::CV_CONV;
                end
            end
            tca_pkg::CV_SHUT: begin
                if (!st.sd) begin
                    next_st.cv = tca_pkg::CV_CONV;
                    next_st.timer = '0;
                end else if (osReq) begin
                    next_st.cv = tca_pkg::CV_CONV;
                    next_st.timer = '0;
                    next_st.oneShot = 1'b1;
                end
            end
            // One-shot request outside shutdown falls through unused
            default: next_st.cv = tca_pkg::CV_SHUT;
        endcase
        next_st.convBusy = (next_st.cv == tca_pkg::CV_CONV);

        // A read clears first so a same-cycle trigger still wins
        if (st.tm && readEv) begin
            next_st.flag = 1'b0;
        end
        if (convDone) begin
            next_st.temp = sampled;
            // One step of the queue per result
            next_st.hiCnt = ($signed(sampled) >= $signed(maskRes(st.high, st.em))) ?
                            satInc(st.hiCnt) : 3'h0;
            next_st.loCnt = ($signed(sampled) <= $signed(maskRes(st.low, st.em))) ?
                            satInc(st.loCnt) : 3'h0;
            if (!st.tm) begin
                if (next_st.hiCnt >= depth) begin
                    next_st.flag = 1'b1;
                end else if (next_st.loCnt >= depth) begin
                    next_st.flag = 1'b0;
                end
            end else if (st.waitHigh && next_st.hiCnt >= depth) begin
                setEv = 1'b1;
                next_st.flag = 1'b1;
                next_st.waitHigh = 1'b0;
            end else if (!st.waitHigh && next_st.loCnt >= depth) begin
                setEv = 1'b1;
                next_st.flag = 1'b1;
                next_st.waitHigh = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.sclS1 <= 1'b1;
            st.sclS2 <= 1'b1;
            st.sclS3 <= 1'b1;
            st.sdaS1 <= 1'b1;
            st.sdaS2 <= 1'b1;
            st.sdaS3 <= 1'b1;
            st.sdaOeN <= 1'b1;
            st.cv <= tca_pkg::CV_CONV;
            st.convBusy <= 1'b1;
            st.temp <= tca_pkg::TEMP_RST;
            st.low <= tca_pkg::LOW_RST;
            st.high <= tca_pkg::HIGH_RST;
            st.fq <= tca_pkg::CFG_RST[tca_pkg::CFG_FQ_LO +: 2];
            st.tm <= tca_pkg::CFG_RST[tca_pkg::CFG_TM_BIT];
            st.sd <= tca_pkg::CFG_RST[tca_pkg::CFG_SD_BIT];
            st.em <= tca_pkg::CFG_RST[tca_pkg::CFG_EM_BIT];
            st.cr <= tca_pkg::CFG_RST[tca_pkg::CFG_CR_LO +: 2];
            st.waitHigh <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign sdaOut = st.sdaOut;
    assign sdaOeN = st.sdaOeN;
    assign convActive = st.convBusy;
    assign overTempFlag = st.flag;

    chk_os_cont_zero: assert property (@(posedge clock) disable iff (!resetn)
        (st.cv != tca_pkg::CV_SHUT && !st.oneShot) |=> !cfgWord[tca_pkg::CFG_OS_BIT])
        else $error("one-shot bit reads one in continuous mode");
    chk_os_busy_one: assert property (@(posedge clock) disable iff (!resetn)
        (st.oneShot |-> (cfgWord[0] && st.cv == tca_pkg::CV_CONV)))
        else $error("one-shot bit not shown while single conversion runs");
    chk_conv_end: assert property (@(posedge clock) disable iff (!resetn)
        (st.cv == tca_pkg::CV_CONV && st.timer == CONV_LAST) |=> !st.convBusy)
        else $error("conversion did not end on time");
    chk_shut_stays: assert property (@(posedge clock) disable iff (!resetn)
        (st.cv == tca_pkg::CV_SHUT && st.sd && !osReq) |=> st.cv == tca_pkg::CV_SHUT)
        else $error("left shutdown without cause");
    chk_resume_conv: assert property (@(posedge clock) disable iff (!resetn)
        (st.cv == tca_pkg::CV_SHUT && !st.sd) |=> (st.convBusy && st.timer == '0))
        else $error("clearing shutdown did not resume conversion");
    chk_oneshot_back: assert property (@(posedge clock) disable iff (!resetn)
        (convDone && st.oneShot) |=> (st.cv == tca_pkg::CV_SHUT && !st.oneShot))
        else $error("single conversion did not return to shutdown");
    chk_result_store: assert property (@(posedge clock) disable iff (!resetn)
        convDone |=> st.temp == $past(sampled))
        else $error("result register not updated");
    chk_comp_set: assert property (@(posedge clock) disable iff (!resetn)
        (convDone && !st.tm && next_st.hiCnt >= depth) |=> st.flag)
        else $error("comparator flag not set after queue");
    chk_comp_clear: assert property (@(posedge clock) disable iff (!resetn)
        (convDone && !st.tm && next_st.hiCnt < depth && next_st.loCnt >= depth) |=> !st.flag)
        else $error("comparator flag not cleared after low queue");
    chk_read_clear: assert property (@(posedge clock) disable iff (!resetn)
        (st.tm && readEv && !setEv) |=> !st.flag)
        else $error("read did not clear interrupt flag");
    chk_addr_match: assert property (@(posedge clock) disable iff (!resetn)
        (st.i2c == tca_pkg::I_ACK && st.byteIdx == 3'h0) |->
        st.shift[7:1] == {tca_pkg::ADDR_BASE7[6:3], st.addrS2})
        else $error("acknowledged a foreign address");
    chk_data_stable: assert property (@(posedge clock) disable iff (!resetn)
        (st.sclS2 && st.sclS3 && !startEv && !stopEv) |=> $stable(st.sdaOeN))
        else $error("data driven while clock high");
endmodule : tca_temp_alarm_ctrl

// ### dv/tca_i2c_host.sv
// Two-wire bus host model: clock, start, stop and byte transfers
`timescale 1ns/10ps
module tca_i2c_host (
    output logic sclLine,
    output logic sdaRelease,
    input wire logic sdaLine
);
    logic [6:0] devAddr = 7'h4d;
    initial begin
        sclLine = 1'b1;
        sdaRelease = 1'b1;
    end
    // Data moves only while the clock is low
    task automatic bitIo(input logic d, output logic q);
        #200 sdaRelease = d;
        #200 sclLine = 1'b1;
        #200 q = sdaLine;
        #200 sclLine = 1'b0;
    endtask : bitIo
    // Host alone forms start and stop; clock stands high between frames
    task automatic start();
        #200 sdaRelease = 1'b1;
        #200 sclLine = 1'b1;
        #200 sdaRelease = 1'b0;
        #200 sclLine = 1'b0;
    endtask : start
    task automatic stop();
        #200 sdaRelease = 1'b0;
        #200 sclLine = 1'b1;
        #200 sdaRelease = 1'b1;
        #200;
    endtask : stop
    task automatic byteIo(input logic [7:0] d, input logic hAck, output logic [7:0] q,
                          output logic dAck);
        for (int i = 7; i >= 0; i--) begin
            bitIo(d[i], q[i]);
        end
        bitIo(hAck, dAck);
    endtask : byteIo
    task automatic wrReg(input logic [7:0] ptr, input logic [15:0] val, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start();
        byteIo({devAddr, 1'b0}, 1'b1, q, a0);
        byteIo(ptr, 1'b1, q, a1);
        byteIo(val[15:8], 1'b1, q, a2);
        byteIo(val[7:0], 1'b1, q, a3);
        stop();
        ok = !(a0 | a1 | a2 | a3);
    endtask : wrReg
    // Pointer write, repeated start, then two data bytes with ack and nack
    task automatic rdReg(input logic [7:0] ptr, output logic [15:0] val);
        logic [7:0] q;
        logic a;
        start();
        byteIo({devAddr, 1'b0}, 1'b1, q, a);
        byteIo(ptr, 1'b1, q, a);
        start();
        byteIo({devAddr, 1'b1}, 1'b1, q, a);
        byteIo(8'hff, 1'b0, val[15:8], a);
        byteIo(8'hff, 1'b1, val[7:0], a);
        stop();
    endtask : rdReg
endmodule : tca_i2c_host

// ### dv/tb.sv
// Self-checking bench for the temperature alarm controller
`timescale 1ns/10ps
module tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] addrSel = 3'h5;
    logic [15:0] tempSample = 16'h1000;
    logic sclLine, sdaRelease, sdaOut, sdaOeN, convActive, overTempFlag, ok;
    logic [15:0] rd;
    int miscompares = 0;
    int n_checks = 0;
    // Pull-up: line high unless some party pulls it
    wire logic sdaLine = sdaRelease & (sdaOeN | sdaOut);
    initial begin
        forever #50 clock = ~clock;
    end
    tca_i2c_host host_u (.sclLine(sclLine), .sdaRelease(sdaRelease), .sdaLine(sdaLine));
    // Short timebase keeps the run small; rates stay above the conversion time
    tca_temp_alarm_ctrl #(.CONV_CYC(800), .RATE0_CYC(3000), .RATE1_CYC(2000),
        .RATE2_CYC(1500), .RATE3_CYC(1000)) dut_u (.clock(clock), .resetn(resetn),
        .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .addrSel(addrSel), .tempSample(tempSample), .convActive(convActive),
        .overTempFlag(overTempFlag));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic doReset();
        resetn = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
    endtask : doReset
    task automatic waitEnd();
        int n = 0;
        while (convActive !== 1'b1 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        while (convActive !== 1'b0 && n < 8000) begin
            @(negedge clock);
            n++;
        end
        repeat (3) @(negedge clock);
        chk(16'(n < 8000), 16'h1);
    endtask : waitEnd
    task automatic idleCount();
        int n = 0;
        repeat (3500) begin
            @(negedge clock);
            if (convActive !== 1'b0) n++;
        end
        chk(16'(n), 16'h0);
    endtask : idleCount
    task automatic testDefaults();
        host_u.rdReg(8'h01, rd);
        chk(rd, 16'h00c0);
        host_u.rdReg(8'h02, rd);
        chk(rd, 16'h4b00);
        host_u.devAddr = 7'h48;
        host_u.wrReg(8'h03, 16'h1111, ok);
        chk({15'h0, ok}, 16'h0);
        host_u.devAddr = 7'h4d;
        host_u.rdReg(8'h03, rd);
        chk(rd, 16'h5000);
        $display("test defaults done");
    endtask : testDefaults
    task automatic testComparator();
        host_u.wrReg(8'h01, 16'h0880, ok);
        chk({15'h0, ok}, 16'h1);
        tempSample = 16'h5000;
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h0);
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h1);
        host_u.wrReg(8'h00, 16'h0123, ok);
        chk({15'h0, ok}, 16'h1);
        host_u.rdReg(8'h00, rd);
        chk(rd, 16'h5000);
        tempSample = 16'h4b01;
        waitEnd();
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h1);
        tempSample = 16'h4b00;
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h1);
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h0);
        $display("test comparator done");
    endtask : testComparator
    task automatic testShutdown();
        host_u.wrReg(8'h01, 16'h0180, ok);
        repeat (900) @(negedge clock);
        idleCount();
        host_u.wrReg(8'h01, 16'h0181, ok);
        host_u.rdReg(8'h01, rd);
        chk(rd, 16'h01c1);
        waitEnd();
        host_u.rdReg(8'h01, rd);
        chk(rd, 16'h01c0);
        idleCount();
        host_u.wrReg(8'h01, 16'h0080, ok);
        chk({15'h0, convActive}, 16'h1);
        host_u.wrReg(8'h01, 16'h0081, ok);
        host_u.rdReg(8'h01, rd);
        chk(rd, 16'h00c0);
        $display("test shutdown done");
    endtask : testShutdown
    // Fastest rate and deepest queue, then shutdown written mid-conversion
    task automatic testRate();
        int hi = 0;
        int lo = 0;
        host_u.wrReg(8'h01, 16'h1886, ok);
        chk({15'h0, ok}, 16'h1);
        tempSample = 16'h5000;
        repeat (5) waitEnd();
        chk({15'h0, overTempFlag}, 16'h0);
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h1);
        while (convActive !== 1'b1 && lo < 4000) begin
            @(negedge clock);
            lo++;
        end
        while (convActive === 1'b1 && hi < 4000) begin
            @(negedge clock);
            hi++;
        end
        lo = 0;
        while (convActive === 1'b0 && lo < 4000) begin
            @(negedge clock);
            lo++;
        end
        // Bench timebase: 800 cycles converting, 1000 cycles per period
        chk(16'(hi), 16'h0320);
        chk(16'(lo), 16'h00c8);
        host_u.wrReg(8'h01, 16'h0186, ok);
        chk({15'h0, convActive}, 16'h1);
        waitEnd();
        idleCount();
        $display("test rate done");
    endtask : testRate
    task automatic testInterrupt();
        doReset();
        host_u.wrReg(8'h01, 16'h0280, ok);
        tempSample = 16'h5000;
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h1);
        host_u.rdReg(8'h02, rd);
        chk({15'h0, overTempFlag}, 16'h0);
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h0);
        tempSample = 16'h4b00;
        waitEnd();
        chk({15'h0, overTempFlag}, 16'h1);
        host_u.wrReg(8'h01, 16'h0000, ok);
        host_u.wrReg(8'h02, 16'h1235, ok);
        host_u.rdReg(8'h02, rd);
        chk(rd, 16'h1234);
        host_u.wrReg(8'h01, 16'h0080, ok);
        host_u.rdReg(8'h02, rd);
        chk(rd, 16'h1234);
        $display("test interrupt done");
    endtask : testInterrupt
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        doReset();
        testDefaults();
        testComparator();
        testShutdown();
        testRate();
        testInterrupt();
        stop_test();
    end
    initial begin
        repeat (95000) @(posedge clock);
        miscompares++;
        stop_test();
    end
endmodule : tb
